// file: src/ibp_master.sv
// byte-wide two-wire bus master with an Avalon-MM register slave
// assumes open-drain pads outside; lines are pulled up externally
`timescale 1ns/1ps

module ibp_master
  import ibp_pkg::*;
(
  input wire logic i_mclk, // system clock, 40 MHz
  input wire logic i_sys_rst, // synchronous reset, high
  input wire logic [ADDR_W-1:0] i_avs_address, // byte address
  input wire logic i_avs_read, // read request
  input wire logic i_avs_write, // write request
  input wire logic [31:0] i_avs_writedata, // write data
  output logic [31:0] o_avs_readdata, // read data
  output logic o_avs_waitrequest, // stall
  output logic o_irq, // interrupt level
  input wire logic i_scl, // clock line level
  output logic o_scl, // clock line drive value
  output logic o_scl_oe_n, // low while pulling clock low
  input wire logic i_sda, // data line level
  output logic o_sda, // data line drive value
  output logic o_sda_oe_n // low while pulling data low
);
  ibp_cfg_type cfg;
  ibp_state_type state;
  ibp_pins_type line;
  logic [7:0] target_select;
  logic [7:0] serial_tx_byte;
  logic [7:0] serial_rx_byte;
  logic [2:0] evt_status;
  logic [2:0] evt_mask;
  logic rx_full_flag;
  logic bus_err;
  logic tx_pending;
  logic tx_empty_flag;
  logic addr_dirty;
  logic ack;
  logic tick;
  logic [15:0] idx;
  logic wr_hit;
  logic rd_hit;
  logic [7:0] wbyte;
  logic [1:0] phase;
  logic [3:0] bitcnt;
  logic [7:0] shift;
  logic sending;
  logic is_addr;
  logic last_rd;
  logic scl_low;
  logic sda_low;
  logic set_err;
  logic set_rx;
  logic consume;
  logic rx_data_read;
  logic [7:0] ctrl_view;

  // hardware set wins over a clear in the same cycle
  function automatic logic sticky(input logic cur, input logic set,
                                  input logic clr);
    sticky = set | (cur & ~clr);
  endfunction

  ibp_pin_sync u_sync (
    .i_mclk(i_mclk),
    .i_sys_rst(i_sys_rst),
    .i_pins('{scl: i_scl, sda: i_sda}),
    .o_pins(line)
  );

  ibp_tick_div u_div (
    .i_mclk(i_mclk),
    .i_sys_rst(i_sys_rst),
    .i_fast(cfg.fast),
    .o_tick(tick)
  );

  // bus slave: every access holds one wait cycle, then completes
  assign idx = i_avs_address[ADDR_W-1:2];
  assign wbyte = i_avs_writedata[7:0];
  assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~ack;
  assign wr_hit = i_avs_write & ack;
  assign rd_hit = i_avs_read & ack;
  assign rx_data_read = rd_hit && idx == IDX_RX_BYTE;

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      ack <= 1'b0;
    end else begin
      ack <= (i_avs_read | i_avs_write) & ~ack;
    end
  end

  assign tx_empty_flag = ~tx_pending;
  always_comb begin
    ctrl_view = 8'h00;
    ctrl_view[CTL_STOP_WR] = cfg.stop_after_write;
    ctrl_view[CTL_STOP_RD] = cfg.stop_after_read;
    ctrl_view[CTL_TX_IRQ_EN] = cfg.tx_empty_irq_en;
    ctrl_view[CTL_TX_EMPTY] = tx_empty_flag;
    ctrl_view[CTL_FAST] = cfg.fast;
    ctrl_view[CTL_BUS_ERR] = bus_err;
    ctrl_view[CTL_RX_IRQ_EN] = cfg.rx_ready_irq_en;
    ctrl_view[CTL_RX_FULL] = rx_full_flag;
  end

  // read data is captured in the wait cycle so it stands at completion
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      o_avs_readdata <= 32'h0000_0000;
    end else if (i_avs_read & ~ack) begin
      case (idx)
        IDX_CTRL: o_avs_readdata <= {24'h000000, ctrl_view};
        IDX_RX_BYTE: o_avs_readdata <= {24'h000000, serial_rx_byte};
        IDX_TARGET: o_avs_readdata <= {24'h000000, target_select};
        IDX_EVT_STATUS: o_avs_readdata <= {29'h00000000, evt_status};
        IDX_EVT_MASK: o_avs_readdata <= {29'h00000000, evt_mask};
        default: o_avs_readdata <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      cfg <= ibp_cfg_type'({RST_CTRL_WR[CTL_STOP_WR], RST_CTRL_WR[1],
                            RST_CTRL_WR[2], RST_CTRL_WR[4],
                            RST_CTRL_WR[6]});
    end else if (wr_hit && idx == IDX_CTRL) begin
      cfg.stop_after_write <= wbyte[CTL_STOP_WR];
      cfg.stop_after_read <= wbyte[CTL_STOP_RD];
      cfg.tx_empty_irq_en <= wbyte[CTL_TX_IRQ_EN];
      cfg.fast <= wbyte[CTL_FAST];
      cfg.rx_ready_irq_en <= wbyte[CTL_RX_IRQ_EN];
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      target_select <= RST_TARGET;
      addr_dirty <= 1'b1;
    end else if (wr_hit && idx == IDX_TARGET) begin
      target_select <= wbyte;
      addr_dirty <= 1'b1;
    end else if (state == ST_START) begin
      addr_dirty <= 1'b0;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      serial_tx_byte <= RST_TX_BYTE;
      tx_pending <= 1'b0;
    end else if (wr_hit && idx == IDX_TX_BYTE) begin
      serial_tx_byte <= wbyte;
      tx_pending <= 1'b1;
    end else if (consume || set_err) begin
      tx_pending <= 1'b0;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      serial_rx_byte <= RST_RX_BYTE;
      rx_full_flag <= 1'b0;
      bus_err <= 1'b0;
    end else begin
      if (set_rx) begin
        serial_rx_byte <= shift;
      end
      rx_full_flag <= sticky(rx_full_flag, set_rx,
        rx_data_read);
      bus_err <= sticky(bus_err, set_err,
        wr_hit && idx == IDX_CTRL && wbyte[CTL_BUS_ERR]);
    end
  end

  // sticky event bits, cleared by writing ones
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      evt_status <= RST_EVT;
      evt_mask <= RST_EVT;
    end else begin
      for (int i = 0; i < 3; i++) begin
        evt_status[i] <= sticky(evt_status[i],
          i == EVT_RX_FULL ? set_rx : (i == EVT_TX_EMPTY ? consume : set_err),
          wr_hit && idx == IDX_EVT_STATUS && wbyte[i]);
      end
      if (wr_hit && idx == IDX_EVT_MASK) begin
        evt_mask <= wbyte[2:0];
      end
    end
  end

  assign o_irq = (rx_full_flag & cfg.rx_ready_irq_en)
               | (tx_empty_flag & cfg.tx_empty_irq_en)
               | (|(evt_status & evt_mask));

  // open drain: value is always low, enable low while pulling down
  assign o_scl = 1'b0;
  assign o_sda = 1'b0;
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      o_scl_oe_n <= 1'b1;
      o_sda_oe_n <= 1'b1;
    end else begin
      o_scl_oe_n <= ~scl_low;
      o_sda_oe_n <= ~sda_low;
    end
  end

  // byte engine; four quarter-bit phases per bit, ninth bit is the ack
  always_comb begin
    set_err = 1'b0;
    set_rx = 1'b0;
    consume = 1'b0;
    if (tick && phase == 2'h3 && state == ST_BIT && bitcnt == 4'h8) begin
      set_err = sending & line.sda;
      set_rx = ~sending;
      consume = is_addr & ~line.sda;
    end
    if (tick && state == ST_HOLD && tx_pending && !addr_dirty) begin
      consume = 1'b1;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      state <= ST_IDLE;
      phase <= 2'h0;
      bitcnt <= 4'h0;
      shift <= 8'h00;
      sending <= 1'b0;
      is_addr <= 1'b0;
      last_rd <= 1'b0;
      scl_low <= 1'b0;
      sda_low <= 1'b0;
    end else if (tick) begin
      case (state)
        ST_IDLE: begin
          scl_low <= 1'b0;
          sda_low <= 1'b0;
          phase <= 2'h0;
          if (tx_pending) begin
            state <= ST_START;
          end
        end
        ST_START: begin
          phase <= phase + 2'h1;
          case (phase)
            2'h0: sda_low <= 1'b0;
            2'h1: scl_low <= 1'b0;
            2'h2: begin
              // a stretched clock holds the start until the line is high
              if (line.scl) begin
                sda_low <= 1'b1;
              end else begin
                phase <= phase;
              end
            end
            default: begin
              scl_low <= 1'b1;
              shift <= target_select;
              sending <= 1'b1;
              is_addr <= 1'b1;
              bitcnt <= 4'h0;
              state <= ST_BIT;
            end
          endcase
        end
        ST_BIT: begin
          phase <= phase + 2'h1;
          case (phase)
            2'h0: begin
              if (bitcnt == 4'h8) begin
                // master acks each read byte but nacks the last one
                sda_low <= ~sending & ~last_rd;
              end else begin
                sda_low <= sending & ~shift[7];
              end
            end
            2'h1: scl_low <= 1'b0;
            2'h2: begin
              if (!line.scl) begin
                phase <= phase;
              end else if (bitcnt != 4'h8) begin
                shift <= {shift[6:0], line.sda};
              end
            end
            default: begin
              scl_low <= 1'b1;
              bitcnt <= bitcnt + 4'h1;
              if (bitcnt == 4'h8) begin
                bitcnt <= 4'h0;
                // data line keeps its level until the clock is low
                is_addr <= 1'b0;
                if (sending && line.sda) begin
                  state <= ST_STOP;
                end else if (is_addr && !target_select[TGT_DIR]) begin
                  shift <= serial_tx_byte;
                end else if (is_addr) begin
                  sending <= 1'b0;
                  last_rd <= cfg.stop_after_read;
                end else if (sending) begin
                  state <= cfg.stop_after_write ? ST_STOP : ST_HOLD;
                end else begin
                  state <= last_rd ? ST_STOP : ST_HOLD;
                end
              end
            end
          endcase
        end
        ST_HOLD: begin
          // clock held low until firmware supplies the next byte
          phase <= 2'h0;
          if (tx_pending && addr_dirty) begin
            state <= ST_START;
          end else if (tx_pending) begin
            shift <= serial_tx_byte;
            sending <= ~target_select[TGT_DIR];
            last_rd <= cfg.stop_after_read;
            state <= ST_BIT;
          end
        end
        ST_STOP: begin
          phase <= phase + 2'h1;
          case (phase)
            2'h0: sda_low <= 1'b1;
            2'h1: scl_low <= 1'b0;
            2'h2: begin
              if (!line.scl) begin
                phase <= phase;
              end
            end
            default: begin
              sda_low <= 1'b0;
              state <= ST_IDLE;
            end
          endcase
        end
        default: state <= ST_IDLE;
      endcase
    end
  end
endmodule

// file: src/ibp_pkg.sv
// package for the byte-wide two-wire master port
// assumes a 40 MHz system clock and a word-wide bus slave at the top
package ibp_pkg;

  // register indices; byte address on the bus is four times the index
  localparam logic [15:0] IDX_CTRL = 16'hFFF0;
  localparam logic [15:0] IDX_TX_BYTE = 16'hFFF1;
  localparam logic [15:0] IDX_RX_BYTE = 16'hFFF2;
  localparam logic [15:0] IDX_TARGET = 16'hFFF3;
  localparam logic [15:0] IDX_EVT_STATUS = 16'hFFF4;
  localparam logic [15:0] IDX_EVT_MASK = 16'hFFF5;
  localparam int ADDR_W = 18;

  // control/status field positions
  localparam int CTL_STOP_WR = 0;
  localparam int CTL_STOP_RD = 1;
  localparam int CTL_TX_IRQ_EN = 2;
  localparam int CTL_TX_EMPTY = 3;
  localparam int CTL_FAST = 4;
  localparam int CTL_BUS_ERR = 5;
  localparam int CTL_RX_IRQ_EN = 6;
  localparam int CTL_RX_FULL = 7;

  // target select field positions
  localparam int TGT_DIR = 0;
  localparam int TGT_ADDR_LSB = 1;

  // sticky event status bits
  localparam int EVT_RX_FULL = 0;
  localparam int EVT_TX_EMPTY = 1;
  localparam int EVT_BUS_ERR = 2;

  // reset values
  localparam logic [7:0] RST_CTRL_WR = 8'h00;
  localparam logic [7:0] RST_TX_BYTE = 8'h00;
  localparam logic [7:0] RST_RX_BYTE = 8'h00;
  localparam logic [7:0] RST_TARGET = 8'h00;
  localparam logic [2:0] RST_EVT = 3'h0;

  // timing: the divider ticks four times per serial bit
  localparam int CLK_PERIOD_PS = 25000;
  localparam int FAST_BIT_PS = 2500000;
  localparam int SLOW_BIT_PS = 10000000;
  localparam int QTR_FAST_INT = (FAST_BIT_PS / 4 + CLK_PERIOD_PS - 1)
                                / CLK_PERIOD_PS;
  localparam int QTR_SLOW_INT = (SLOW_BIT_PS / 4 + CLK_PERIOD_PS - 1)
                                / CLK_PERIOD_PS;
  localparam logic [6:0] QTR_FAST_CYC = 7'(QTR_FAST_INT);
  localparam logic [6:0] QTR_SLOW_CYC = 7'(QTR_SLOW_INT);

  typedef struct packed {
    logic stop_after_write;
    logic stop_after_read;
    logic tx_empty_irq_en;
    logic fast;
    logic rx_ready_irq_en;
  } ibp_cfg_type;

  typedef struct packed {
    logic scl;
    logic sda;
  } ibp_pins_type;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_START = 5'h02,
    ST_BIT = 5'h04,
    ST_HOLD = 5'h08,
    ST_STOP = 5'h10
  } ibp_state_type;

endpackage

// file: src/ibp_pin_sync.sv
// three-stage synchroniser for the two bus lines
// assumes lines idle high; output moves once stages two and three agree
`timescale 1ns/1ps
module ibp_pin_sync
  import ibp_pkg::*;
(
  input wire logic i_mclk, // system clock
  input wire logic i_sys_rst, // synchronous reset, high
  input wire ibp_pins_type i_pins, // raw line levels
  output ibp_pins_type o_pins // filtered line levels
);
  ibp_pins_type s1;
  ibp_pins_type s2;
  ibp_pins_type s3;

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      s1 <= '1;
      s2 <= '1;
      s3 <= '1;
    end else begin
      s1 <= i_pins;
      s2 <= s1;
      s3 <= s2;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      o_pins <= '1;
    end else if (s2 == s3) begin
      o_pins <= s3;
    end
  end
endmodule

// file: src/ibp_tick_div.sv
// quarter-bit tick divider with selectable bus rate
// assumes the rate select is steady while a byte is on the bus
`timescale 1ns/1ps
module ibp_tick_div
  import ibp_pkg::*;
(
  input wire logic i_mclk, // system clock
  input wire logic i_sys_rst, // synchronous reset, high
  input wire logic i_fast, // high selects the fast rate
  output logic o_tick // one-cycle enable pulse
);
  logic [6:0] count;
  logic [6:0] limit;

  assign limit = i_fast ? QTR_FAST_CYC : QTR_SLOW_CYC;

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      count <= 7'h00;
      o_tick <= 1'b0;
    end else if (count >= limit - 7'h01) begin
      count <= 7'h00;
      o_tick <= 1'b1;
    end else begin
      count <= count + 7'h01;
      o_tick <= 1'b0;
    end
  end
endmodule

// file: tb/ibp_master_properties.sv
// concurrent checks on the master port's register bus and line drives
// assumes it is bound into ibp_master and sees only that module's ports
`timescale 1ns/1ps
module ibp_master_properties
  import ibp_pkg::*;
(
  input wire logic i_mclk, // system clock
  input wire logic i_sys_rst, // synchronous reset, high
  input wire logic [ADDR_W-1:0] i_avs_address, // byte address
  input wire logic i_avs_read, // read request
  input wire logic i_avs_write, // write request
  input wire logic [31:0] i_avs_writedata, // write data
  input wire logic [31:0] o_avs_readdata, // read data
  input wire logic o_avs_waitrequest, // stall
  input wire logic o_irq, // interrupt level
  input wire logic i_scl, // clock line level
  input wire logic o_scl, // clock line drive value
  input wire logic o_scl_oe_n, // low while pulling clock low
  input wire logic i_sda, // data line level
  input wire logic o_sda, // data line drive value
  input wire logic o_sda_oe_n // low while pulling data low
);
  logic fast_q;
  logic rx_seen;
  logic [7:0] gap_cnt;
  logic [8:0] hi_cnt;
  wire rd_done = i_avs_read && !o_avs_waitrequest;
  wire wr_done = i_avs_write && !o_avs_waitrequest;
  wire [15:0] idx = i_avs_address[17:2];

  default clocking cb @(posedge i_mclk); endclocking

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) fast_q <= 1'b0;
    else if (wr_done && idx == IDX_CTRL) fast_q <= i_avs_writedata[CTL_FAST];
  end
  // a byte takes far longer than the gap, so no new data can land in it
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      rx_seen <= 1'b0;
      gap_cnt <= 8'h00;
    end else if (rd_done && idx == IDX_RX_BYTE) begin
      rx_seen <= 1'b1;
      gap_cnt <= 8'h00;
    end else if (gap_cnt != 8'hFF) gap_cnt <= gap_cnt + 8'h01;
  end
  // high time of the clock line; a data edge restarts it (start condition)
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst || !o_scl_oe_n || $changed(o_sda_oe_n)) hi_cnt <= 9'h000;
    else if (hi_cnt != 9'h1FF) hi_cnt <= hi_cnt + 9'h001;
  end

  one_wait_cycle_a: assert property (
    disable iff (i_sys_rst) (i_avs_read || i_avs_write) && o_avs_waitrequest
    |=> !o_avs_waitrequest) else $error("bus wait longer than one cycle");
  tx_read_zero_a: assert property (
    disable iff (i_sys_rst) rd_done && idx == IDX_TX_BYTE
    |-> o_avs_readdata == 32'h0) else $error("transmit byte readable");
  upper_zero_a: assert property (
    disable iff (i_sys_rst) rd_done |-> o_avs_readdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  rx_full_clear_a: assert property (
    disable iff (i_sys_rst) rd_done && idx == IDX_CTRL && rx_seen &&
    gap_cnt < 8'h14 |-> !o_avs_readdata[CTL_RX_FULL])
    else $error("receiver full not cleared by read");
  lines_idle_a: assert property (
    i_sys_rst |=> o_scl_oe_n && o_sda_oe_n)
    else $error("lines driven after reset");
  irq_reset_a: assert property (
    i_sys_rst |=> !o_irq) else $error("interrupt high after reset");
  drive_low_a: assert property (!o_scl && !o_sda)
    else $error("open-drain drive value not low");
  start_after_tx_a: assert property (
    disable iff (i_sys_rst) wr_done && idx == IDX_TX_BYTE && o_scl_oe_n &&
    o_sda_oe_n |-> ##[1:410] ($fell(o_sda_oe_n) && o_scl_oe_n))
    else $error("no start after transmit write");
  scl_high_time_a: assert property (
    disable iff (i_sys_rst) $fell(o_scl_oe_n) |-> (fast_q ?
    (hi_cnt >= 9'h014 && hi_cnt <= 9'h050) :
    (hi_cnt >= 9'h050 && hi_cnt <= 9'h140)))
    else $error("clock high time off rate");

  cov_rx_read: cover property (rd_done && idx == IDX_RX_BYTE);
  cov_start: cover property ($fell(o_sda_oe_n) && o_scl_oe_n);
  cov_fast_bit: cover property ($fell(o_scl_oe_n) && fast_q);
endmodule

bind ibp_master ibp_master_properties chk (.i_mclk, .i_sys_rst,
  .i_avs_address, .i_avs_read, .i_avs_write, .i_avs_writedata,
  .o_avs_readdata, .o_avs_waitrequest, .o_irq, .i_scl, .o_scl, .o_scl_oe_n,
  .i_sda, .o_sda, .o_sda_oe_n);

// file: tb/ibp_eeprom_model.sv
// behavioural two-wire memory target for the master port bench
// assumes both lines pulled up outside; it never stretches the clock
`timescale 1ns/1ps
module ibp_eeprom_model #(
  parameter logic [6:0] TGT_ADDR = 7'h50 // device address
) (
  input wire logic i_scl, // clock line level
  input wire logic i_sda, // data line level
  input wire logic [7:0] i_rd_byte, // byte returned on reads
  output logic o_sda_oe_n, // low while pulling data low
  output logic [7:0] o_last_wr, // last byte written to us
  output logic [7:0] o_bytes, // data bytes completed
  output logic [7:0] o_stops // stop conditions seen
);
  logic busy, in_addr, rd_mode, sel, mack;
  logic [3:0] bit_n;
  logic [7:0] sh;
  initial begin
    o_sda_oe_n = 1'b1;
    o_last_wr = 8'h00;
    o_bytes = 8'h00;
    o_stops = 8'h00;
    busy = 1'b0;
    sel = 1'b0;
    bit_n = 4'h0;
  end
  // a start restarts framing even mid-byte, so repeated starts work
  always @(negedge i_sda) if (i_scl) begin
    busy = 1'b1;
    in_addr = 1'b1;
    rd_mode = 1'b0;
    // the clock fall that ends the start wraps this to bit zero
    bit_n = 4'hF;
  end
  always @(posedge i_sda) if (i_scl && busy) begin
    busy = 1'b0;
    o_stops = o_stops + 8'h01;
  end
  // no minimum timing: the fast rate is accepted like the slow one
  always @(posedge i_scl) if (busy) begin
    if (bit_n < 4'h8) sh = {sh[6:0], i_sda};
    else mack = !i_sda;
  end
  always @(negedge i_scl) if (busy) begin
    bit_n = bit_n + 4'h1;
    if (bit_n == 4'h8) begin
      if (in_addr) sel = (sh[7:1] == TGT_ADDR);
      else if (sel && !rd_mode) o_last_wr = sh;
      o_sda_oe_n = !(sel && !rd_mode);
    end else if (bit_n == 4'h9) begin
      bit_n = 4'h0;
      if (sel && !in_addr) o_bytes = o_bytes + 8'h01;
      if (rd_mode && !mack) sel = 1'b0;
      if (in_addr) rd_mode = sh[0];
      in_addr = 1'b0;
      o_sda_oe_n = !(sel && rd_mode) || i_rd_byte[7];
    end else if (sel && rd_mode) o_sda_oe_n = i_rd_byte[4'h7 - bit_n];
  end
endmodule

// file: tb/ibp_master_bench.sv
// self-checking bench: register bus master, memory target, random data
// assumes the lines are pulled up; only the master drives the clock line
`timescale 1ns/1ps
module ibp_master_bench;
  import ibp_pkg::*;
  logic i_mclk, i_sys_rst, av_rd, av_wr, wait_req, irq;
  logic scl_oe_n, sda_oe_n, m_sda_oe_n;
  logic [ADDR_W-1:0] av_addr;
  logic [31:0] av_wdata, av_rdata, rdata;
  logic [7:0] rd_byte, last_wr, bytes, stops, d, c, b0, s0;
  int bad_count, total_checks;
  wire scl = scl_oe_n;
  wire sda = sda_oe_n & m_sda_oe_n;

  ibp_master uut (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst),
    .i_avs_address(av_addr), .i_avs_read(av_rd), .i_avs_write(av_wr),
    .i_avs_writedata(av_wdata), .o_avs_readdata(av_rdata),
    .o_avs_waitrequest(wait_req), .o_irq(irq), .i_scl(scl), .o_scl(),
    .o_scl_oe_n(scl_oe_n), .i_sda(sda), .o_sda(), .o_sda_oe_n(sda_oe_n));
  ibp_eeprom_model mem (.i_scl(scl), .i_sda(sda), .i_rd_byte(rd_byte),
    .o_sda_oe_n(m_sda_oe_n), .o_last_wr(last_wr), .o_bytes(bytes),
    .o_stops(stops));

  task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task final_report;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task bus(input logic w, input logic [15:0] idx, input logic [7:0] wd);
    @(posedge i_mclk);
    av_addr <= {idx, 2'b00};
    av_wr <= w;
    av_rd <= !w;
    av_wdata <= {24'h0, wd};
    // no wait length is assumed; only the watchdog ends a hang
    do @(posedge i_mclk);
    while (wait_req !== 1'b0);
    rdata = av_rdata;
    av_wr <= 1'b0;
    av_rd <= 1'b0;
  endtask
  // waits for a stop, or for one more completed byte when no stop follows
  task xfer(input logic [7:0] ctl, input logic [7:0] tgt,
            input logic [7:0] tx, input logic to_stop);
    int n;
    bus(1, IDX_CTRL, ctl);
    bus(1, IDX_TARGET, tgt);
    b0 = bytes;
    s0 = stops;
    bus(1, IDX_TX_BYTE, tx);
    bus(0, IDX_CTRL, 8'h00);
    check("tx_empty low", rdata[CTL_TX_EMPTY], 0);
    n = 0;
    while ((to_stop ? stops == s0 : bytes == b0) && n < 20000) begin
      @(posedge i_mclk);
      n++;
    end
    if (n >= 20000) bad_count++;
  endtask
  task irq_is(input logic exp);
    @(negedge i_mclk);
    check("irq", irq, exp);
  endtask
  // address byte: seven address bits, then the direction bit
  function automatic logic [7:0] tgt_byte(input logic [6:0] a,
                                          input logic rd);
    return {a, rd};
  endfunction

  initial begin
    i_mclk = 0;
    forever #12.5 i_mclk = ~i_mclk;
  end
  initial begin
    // about 30k cycles when every looped transfer runs at the slow rate
    repeat (60000) @(posedge i_mclk);
    bad_count++;
    final_report;
  end
  initial begin
    i_sys_rst = 1;
    {av_rd, av_wr, av_addr, av_wdata, rd_byte} = '0;
    d = 8'($urandom(32'hF0F2));
    repeat (3) @(posedge i_mclk);
    i_sys_rst <= 0;
    bus(0, IDX_CTRL, 0);
    check("ctrl reset", rdata, 32'h08);
    bus(0, IDX_TARGET, 0);
    check("target reset", rdata, 0);
    bus(0, IDX_RX_BYTE, 0);
    check("rx reset", rdata, 0);
    bus(0, 16'h0123, 0);
    check("unmapped", rdata, 0);
    d = 8'($urandom);
    bus(1, IDX_TARGET, d);
    bus(0, IDX_TARGET, 0);
    check("target rw", rdata, d);
    bus(1, IDX_RX_BYTE, d);
    bus(0, IDX_RX_BYTE, 0);
    check("rx read only", rdata, 0);
    bus(1, IDX_CTRL, 8'h04);
    irq_is(1);
    bus(1, IDX_CTRL, 8'h00);
    irq_is(0);
    d = 8'($urandom);
    xfer(8'h10, tgt_byte(7'h50, 1'b0), d, 0);
    check("byte held", last_wr, d);
    repeat (300) @(posedge i_mclk);
    check("clock held low", scl_oe_n, 0);
    check("no stop", stops, s0);
    for (int i = 0; i < 3; i++) begin
      d = 8'($urandom);
      c = {3'h0, 1'($urandom), 4'h1};
      xfer(c, tgt_byte(7'h50, 1'b0), d, 1);
      check("byte sent", last_wr, d);
      bus(0, IDX_CTRL, 0);
      check("ctrl flags", rdata & 32'h28, 32'h08);
    end
    rd_byte <= 8'($urandom);
    xfer(8'h52, tgt_byte(7'h50, 1'b1), 8'h00, 1);
    irq_is(1);
    bus(0, IDX_CTRL, 0);
    check("rx full", rdata[CTL_RX_FULL], 1);
    bus(0, IDX_RX_BYTE, 0);
    check("rx byte", rdata, rd_byte);
    bus(0, IDX_CTRL, 0);
    check("rx emptied", rdata[CTL_RX_FULL], 0);
    irq_is(0);
    xfer(8'h11, tgt_byte(7'h33, 1'b0), 8'h5A, 1);
    bus(0, IDX_TX_BYTE, 0);
    check("tx write only", rdata, 0);
    bus(0, IDX_CTRL, 0);
    check("bus error", rdata[CTL_BUS_ERR], 1);
    bus(0, IDX_EVT_STATUS, 0);
    check("error event", rdata[EVT_BUS_ERR], 1);
    bus(1, IDX_EVT_MASK, 8'h04);
    irq_is(1);
    bus(1, IDX_CTRL, 8'h10);
    bus(0, IDX_CTRL, 0);
    check("zero keeps error", rdata[CTL_BUS_ERR], 1);
    bus(1, IDX_CTRL, 8'h30);
    bus(0, IDX_CTRL, 0);
    check("one clears error", rdata[CTL_BUS_ERR], 0);
    bus(1, IDX_EVT_STATUS, 8'h04);
    irq_is(0);
    // a second reset mid-run must restore the defaults
    @(posedge i_mclk);
    i_sys_rst <= 1;
    repeat (2) @(posedge i_mclk);
    i_sys_rst <= 0;
    bus(0, IDX_TARGET, 0);
    check("target after reset", rdata, 0);
    bus(0, IDX_CTRL, 0);
    check("ctrl after reset", rdata, 32'h08);
    final_report;
  end
endmodule
